/* phc_cfg_engine.sv */
// host-bridge configuration engine: wishbone registers to pci config cycles
//
// Our own choices: the Wishbone slave port and the address map.
`include "phc_regs.svh"

module phc_cfg_engine
    import phc_pkg::*;
#(
    parameter bit         HOST_CFG                  = 1'b1,
    parameter int         self_select_ad_bit        = 16,
    parameter int         decoded_select_line_count = 16,
    parameter logic [3:0] WR_RETRIES                = 4'h3
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             wb_rty_o,
    input  wire logic [31:0] pci_ad_i,
    output logic      [31:0] pci_ad_o,
    output logic             pci_ad_oe_n_o,
    output logic      [3:0]  pci_cbe_n_o,
    output logic             pci_cbe_oe_n_o,
    output logic             pci_par_o,
    output logic             pci_par_oe_n_o,
    output logic             pci_frame_n_o,
    output logic             pci_frame_oe_n_o,
    output logic             pci_irdy_n_o,
    output logic             pci_irdy_oe_n_o,
    output logic             pci_req_n_o,
    input  wire logic        pci_gnt_n_i,
    input  wire logic        pci_devsel_n_i,
    input  wire logic        pci_trdy_n_i,
    input  wire logic        pci_stop_n_i,
    input  wire logic        pci_perr_n_i,
    input  wire logic        pci_serr_n_i,
    input  wire logic        ext_idsel_i,
    output logic             self_idsel_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] bswap(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    function automatic logic [15:0] sel_decode(input logic [4:0] dev);
        logic [15:0] r;
        r = 16'h0000;
        if ({27'h0, dev} < decoded_select_line_count && dev < 5'h10) begin
            r[dev[3:0]] = 1'b1;
        end
        return r;
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    phc_pin_in_t pin_raw;
    phc_pin_in_t pin_s;
    logic [38:0] pin_s_bits;

    assign pin_raw = '{ad: pci_ad_i, gnt_n: pci_gnt_n_i, devsel_n: pci_devsel_n_i,
                       trdy_n: pci_trdy_n_i, stop_n: pci_stop_n_i,
                       perr_n: pci_perr_n_i, serr_n: pci_serr_n_i,
                       ext_idsel: ext_idsel_i};
    assign pin_s   = phc_pin_in_t'(pin_s_bits);

    phc_sync_bank #(
        .W       (39),
        .RST_VAL ({32'h0000_0000, 6'h3f, 1'b0})
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pin_raw),
        .q_o   (pin_s_bits)
    );

    // ************************************************************
    // state
    // ************************************************************
    phc_state_t    state_reg;
    phc_term_t     term_reg;
    logic [31:0]   cfg_addr_reg;
    logic [31:0]   busn_reg;
    logic [1:0]    ctrl_reg;
    phc_flags_t    flags_reg;
    logic [31:0]   wdata_reg;
    logic [31:0]   rdata_reg;
    logic          is_wr_reg;
    logic          serr_seen_reg;
    logic          perr_seen_reg;
    logic [3:0]    timer_reg;
    logic [3:0]    tries_reg;

    // ************************************************************
    // decode
    // ************************************************************
    phc_cfg_addr_t cfg;
    logic [7:0]    tgt_bus;
    logic [7:0]    local_bus;
    logic [7:0]    sub_bus;
    logic          is_type0;
    logic          is_type1;
    logic [31:0]   addr_phase;
    logic          bus_req;
    logic          hit_addr;
    logic          hit_data;
    logic          hit_busn;
    logic          hit_ctrl;
    logic          hit_stat;
    logic          wr_blocked;
    phc_flags_t    flag_set;
    phc_flags_t    flag_clr;
    logic          retry_again;

    assign cfg       = phc_cfg_addr_t'(bswap(cfg_addr_reg));
    assign tgt_bus   = cfg_addr_reg[`PHC_ADR_BUS_LSB +: 8];
    assign local_bus = busn_reg[`PHC_BUSN_LOCAL_LSB +: 8];
    assign sub_bus   = busn_reg[`PHC_BUSN_SUB_LSB +: 8];
    assign is_type0  = tgt_bus == local_bus;
    assign is_type1  = tgt_bus > local_bus && tgt_bus <= sub_bus;

    always_comb begin
        if (is_type0) begin
            addr_phase = {sel_decode(cfg.dev), 5'h00, cfg.func, cfg.regnum, 2'b00};
        end else begin
            addr_phase = {8'h00, cfg.bus, cfg.dev, cfg.func, cfg.regnum, 2'b01};
        end
    end

    // registers exist only in the host-configuration build
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !wb_rty_o;
    assign hit_addr = HOST_CFG && wb_adr_i == `PHC_ADDR_OFS;
    assign hit_data = HOST_CFG && wb_adr_i == `PHC_DATA_OFS;
    assign hit_busn = HOST_CFG && wb_adr_i == `PHC_BUSN_OFS;
    assign hit_ctrl = HOST_CFG && wb_adr_i == `PHC_CTRL_OFS;
    assign hit_stat = HOST_CFG && wb_adr_i == `PHC_STAT_OFS;

    assign wr_blocked = ctrl_reg[`PHC_CTRL_WINH_BIT]
                        && |(flags_reg & `PHC_WR_FLAG_MASK);
    assign retry_again = is_wr_reg && term_reg == TERM_RETRY
                         && tries_reg < WR_RETRIES;

    always_comb begin
        flag_set = '0;
        if (state_reg == ST_ANSWER) begin
            if (is_wr_reg) begin
                flag_set.wr_serr   = serr_seen_reg;
                flag_set.wr_perr   = perr_seen_reg;
                flag_set.wr_mabort = term_reg == TERM_MABORT;
                flag_set.wr_tabort = term_reg == TERM_TABORT;
                flag_set.wr_retry  = term_reg == TERM_RETRY;
            end else begin
                flag_set.rd_serr   = serr_seen_reg;
                flag_set.rd_perr   = perr_seen_reg;
                flag_set.rd_tabort = term_reg == TERM_TABORT;
            end
        end
    end

    always_comb begin
        flag_clr = '0;
        if (state_reg == ST_IDLE && bus_req && hit_stat && wb_we_i && wb_sel_i[0]) begin
            flag_clr = phc_flags_t'(wb_dat_i[7:0]);
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            is_wr_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (bus_req && hit_data && !(wb_we_i && wr_blocked)) begin
                        is_wr_reg <= wb_we_i;
                        if (ctrl_reg[`PHC_CTRL_MEN_BIT] && (is_type0 || is_type1)) begin
                            state_reg <= ST_REQ;
                        end else begin
                            state_reg <= ST_STALL;
                        end
                    end
                end
                ST_REQ: begin
                    if (!pin_s.gnt_n) begin
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR:   state_reg <= ST_DATA;
                ST_DATA: begin
                    if ((!pin_s.devsel_n && (!pin_s.trdy_n || !pin_s.stop_n))
                        || (pin_s.devsel_n && !pin_s.stop_n)
                        || timer_reg == `PHC_MABORT_CYCLES) begin
                        state_reg <= ST_TURN;
                    end
                end
                ST_TURN: begin
                    state_reg <= retry_again ? ST_REQ : ST_ANSWER;
                end
                ST_ANSWER: state_reg <= ST_IDLE;
                ST_STALL: begin
                    // never answered: the master's own timeout ends the cycle
                    if (!wb_cyc_i) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default:   state_reg <= ST_IDLE;
            endcase
        end
    end

    // termination, error capture and retry count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_reg      <= TERM_OK;
            timer_reg     <= 4'h0;
            tries_reg     <= 4'h0;
            serr_seen_reg <= 1'b0;
            perr_seen_reg <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
        end else begin
            if (state_reg == ST_IDLE) begin
                tries_reg     <= 4'h0;
                serr_seen_reg <= 1'b0;
                perr_seen_reg <= 1'b0;
            end
            if (state_reg == ST_REQ) begin
                timer_reg <= 4'h0;
            end else if (state_reg == ST_DATA) begin
                timer_reg <= timer_reg + 4'h1;
            end
            if (state_reg == ST_DATA || state_reg == ST_TURN) begin
                if (!pin_s.serr_n) begin
                    serr_seen_reg <= 1'b1;
                end
                if (!pin_s.perr_n) begin
                    perr_seen_reg <= 1'b1;
                end
            end
            if (state_reg == ST_TURN && retry_again) begin
                tries_reg <= tries_reg + 4'h1;
            end
            if (state_reg == ST_DATA) begin
                if (!pin_s.devsel_n && !pin_s.trdy_n) begin
                    term_reg  <= TERM_OK;
                    rdata_reg <= pin_s.ad;
                end else if (!pin_s.devsel_n && !pin_s.stop_n) begin
                    term_reg <= TERM_RETRY;
                end else if (!pin_s.stop_n) begin
                    term_reg <= TERM_TABORT;
                end else if (timer_reg == `PHC_MABORT_CYCLES) begin
                    term_reg <= TERM_MABORT;
                end
            end
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_addr_reg <= `PHC_ADDR_RST;
            busn_reg     <= `PHC_BUSN_RST;
            ctrl_reg     <= `PHC_CTRL_RST;
            wdata_reg    <= 32'h0000_0000;
        end else if (state_reg == ST_IDLE && bus_req && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    if (hit_addr) begin
                        cfg_addr_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                    if (hit_busn) begin
                        busn_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                end
            end
            if (hit_ctrl && wb_sel_i[0]) begin
                ctrl_reg <= wb_dat_i[1:0];
            end
            if (hit_data) begin
                wdata_reg <= wb_dat_i;
            end
        end
    end

    // event happening in the clearing cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    // ************************************************************
    // wishbone answers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_rty_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_rty_o <= 1'b0;
            if (state_reg == ST_IDLE && bus_req) begin
                if (hit_data) begin
                    wb_err_o <= wb_we_i && wr_blocked;
                end else if (hit_addr || hit_busn || hit_ctrl || hit_stat) begin
                    wb_ack_o <= 1'b1;
                    if (hit_addr) begin
                        wb_dat_o <= cfg_addr_reg;
                    end else if (hit_busn) begin
                        wb_dat_o <= busn_reg;
                    end else if (hit_ctrl) begin
                        wb_dat_o <= {30'h0, ctrl_reg};
                    end else begin
                        wb_dat_o <= {24'h0, flags_reg};
                    end
                end else begin
                    wb_err_o <= 1'b1;
                end
            end else if (state_reg == ST_ANSWER) begin
                if (term_reg == TERM_RETRY) begin
                    wb_rty_o <= 1'b1;
                end else begin
                    wb_ack_o <= 1'b1;
                end
                if (is_wr_reg) begin
                    wb_dat_o <= 32'h0000_0000;
                end else if (term_reg == TERM_OK && !serr_seen_reg) begin
                    wb_dat_o <= bswap(rdata_reg);
                end else begin
                    wb_dat_o <= 32'hffff_ffff;
                end
            end
        end
    end

    // ************************************************************
    // pci pins
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pci_req_n_o      <= 1'b1;
            pci_ad_o         <= 32'h0000_0000;
            pci_ad_oe_n_o    <= 1'b1;
            pci_cbe_n_o      <= 4'hf;
            pci_cbe_oe_n_o   <= 1'b1;
            pci_frame_n_o    <= 1'b1;
            pci_frame_oe_n_o <= 1'b1;
            pci_irdy_n_o     <= 1'b1;
            pci_irdy_oe_n_o  <= 1'b1;
        end else begin
            pci_req_n_o      <= 1'b1;
            pci_frame_n_o    <= 1'b1;
            pci_irdy_n_o     <= 1'b1;
            pci_ad_oe_n_o    <= 1'b1;
            pci_cbe_oe_n_o   <= 1'b1;
            pci_frame_oe_n_o <= 1'b1;
            pci_irdy_oe_n_o  <= 1'b1;
            case (state_reg)
                ST_REQ: begin
                    pci_req_n_o <= 1'b0;
                    if (!pin_s.gnt_n) begin
                        pci_frame_n_o    <= 1'b0;
                        pci_frame_oe_n_o <= 1'b0;
                        pci_irdy_oe_n_o  <= 1'b0;
                        pci_ad_o         <= addr_phase;
                        pci_ad_oe_n_o    <= 1'b0;
                        pci_cbe_n_o      <= is_wr_reg ? `PHC_CMD_CFG_WR : `PHC_CMD_CFG_RD;
                        pci_cbe_oe_n_o   <= 1'b0;
                    end
                end
                ST_ADDR, ST_DATA: begin
                    // single data phase: frame rises as irdy falls
                    pci_frame_oe_n_o <= 1'b0;
                    pci_irdy_n_o     <= 1'b0;
                    pci_irdy_oe_n_o  <= 1'b0;
                    pci_ad_o         <= bswap(wdata_reg);
                    pci_ad_oe_n_o    <= !is_wr_reg;
                    pci_cbe_n_o      <= 4'h0;
                    pci_cbe_oe_n_o   <= 1'b0;
                end
                ST_TURN: begin
                    pci_irdy_oe_n_o <= 1'b0;
                end
                default: begin
                    pci_req_n_o <= 1'b1;
                end
            endcase
        end
    end

    // parity follows ad and cbe by one clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pci_par_o      <= 1'b0;
            pci_par_oe_n_o <= 1'b1;
            self_idsel_o   <= 1'b0;
        end else begin
            pci_par_o      <= ^{pci_ad_o, pci_cbe_n_o};
            pci_par_oe_n_o <= pci_ad_oe_n_o;
            // own core ignores the external select in the host build
            self_idsel_o   <= HOST_CFG ? pin_s.ad[self_select_ad_bit]
                                       : pin_s.ext_idsel;
        end
    end

endmodule // phc_cfg_engine

/* phc_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PHC_REGS_SVH
`define PHC_REGS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define PHC_ADDR_OFS       8'h00
`define PHC_DATA_OFS       8'h04
`define PHC_BUSN_OFS       8'h08
`define PHC_CTRL_OFS       8'h0c
`define PHC_STAT_OFS       8'h10

// ************************************************************
// reset values
// ************************************************************
`define PHC_ADDR_RST       32'h0000_0000
`define PHC_BUSN_RST       32'h0000_0000
`define PHC_CTRL_RST       2'h0

// ************************************************************
// field positions
// ************************************************************
`define PHC_ADR_BUS_LSB    8
`define PHC_BUSN_LOCAL_LSB 8
`define PHC_BUSN_SUB_LSB   24
`define PHC_CTRL_MEN_BIT   0
`define PHC_CTRL_WINH_BIT  1
`define PHC_STAT_BUSY_BIT  8
`define PHC_WR_FLAG_MASK   8'hea

// ************************************************************
// pci commands and timing
// ************************************************************
`define PHC_CMD_CFG_RD     4'ha
`define PHC_CMD_CFG_WR     4'hb
`define PHC_MABORT_CYCLES  4'hc

`endif

/* phc_pkg.sv */
// types shared by the configuration engine
package phc_pkg;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_REQ    = 7'h02,
        ST_ADDR   = 7'h04,
        ST_DATA   = 7'h08,
        ST_TURN   = 7'h10,
        ST_ANSWER = 7'h20,
        ST_STALL  = 7'h40
    } phc_state_t;

    typedef enum logic [1:0] {
        TERM_OK     = 2'h0,
        TERM_RETRY  = 2'h1,
        TERM_TABORT = 2'h2,
        TERM_MABORT = 2'h3
    } phc_term_t;

    // pins sampled from the pci bus
    typedef struct packed {
        logic [31:0] ad;
        logic        gnt_n;
        logic        devsel_n;
        logic        trdy_n;
        logic        stop_n;
        logic        perr_n;
        logic        serr_n;
        logic        ext_idsel;
    } phc_pin_in_t;

    // configuration address in pci bit order
    typedef struct packed {
        logic       enable;
        logic [6:0] rsvd;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
        logic [5:0] regnum;
        logic [1:0] low;
    } phc_cfg_addr_t;

    // sticky event flags
    typedef struct packed {
        logic wr_retry;
        logic wr_mabort;
        logic wr_tabort;
        logic rd_tabort;
        logic wr_perr;
        logic rd_perr;
        logic wr_serr;
        logic rd_serr;
    } phc_flags_t;

endpackage

/* phc_sync_bank.sv */
// two-stage synchroniser for a group of pin inputs
module phc_sync_bank #(
    parameter int              W       = 8,
    parameter logic [W-1:0]    RST_VAL = '1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            q_o      <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // phc_sync_bank

/* phc_cfg_engine_asserts.sv */
// concurrent checks on the configuration engine ports
`include "phc_regs.svh"
module phc_cfg_engine_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        wb_rty_o,
    input wire logic [31:0] pci_ad_o,
    input wire logic [3:0]  pci_cbe_n_o,
    input wire logic        pci_frame_n_o,
    input wire logic        pci_irdy_n_o,
    input wire logic        pci_req_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // helpers and checks
    // ****************************************
    logic frame_seen;
    wire  req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !wb_rty_o;
    wire  start = !pci_frame_n_o && pci_irdy_n_o;
    // remembers an address phase within the current bus request
    always_ff @(posedge clk_i) begin
        frame_seen <= (rst_i || !wb_cyc_i) ? 1'b0 : (frame_seen || start);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_reg_ack: assert property (req && wb_adr_i inside {`PHC_ADDR_OFS, `PHC_BUSN_OFS,
        `PHC_CTRL_OFS, `PHC_STAT_OFS} |=> wb_ack_o) else $error("register not acked");
    chk_unmapped_err: assert property (req && wb_adr_i == 8'h14 |=> wb_err_o)
        else $error("unmapped not refused");
    chk_data_via_pci: assert property (wb_ack_o && wb_adr_i == `PHC_DATA_OFS |-> frame_seen)
        else $error("data port answered without pci cycle");
    chk_rd_cmd: assert property (start && !wb_we_i |-> pci_cbe_n_o == `PHC_CMD_CFG_RD)
        else $error("bad read command");
    chk_wr_cmd: assert property (start && wb_we_i |-> pci_cbe_n_o == `PHC_CMD_CFG_WR)
        else $error("bad write command");
    chk_one_phase: assert property (start |=> pci_frame_n_o && !pci_irdy_n_o)
        else $error("frame not single phase");
    chk_type0_sel: assert property (start && !pci_ad_o[1:0] |-> $onehot(pci_ad_o[31:16]))
        else $error("type 0 select not one hot");
    chk_quiet_req: assert property (!pci_req_n_o |-> wb_cyc_i)
        else $error("pci request without bus cycle");
    cover property (wb_ack_o && wb_adr_i == `PHC_DATA_OFS);
    cover property (wb_err_o);
    cover property (start && pci_ad_o[1:0] == 2'h1);
endmodule // phc_cfg_engine_asserts

bind phc_cfg_engine phc_cfg_engine_asserts phc_cfg_engine_asserts_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_rty_o(wb_rty_o),
    .pci_ad_o(pci_ad_o), .pci_cbe_n_o(pci_cbe_n_o), .pci_frame_n_o(pci_frame_n_o),
    .pci_irdy_n_o(pci_irdy_n_o), .pci_req_n_o(pci_req_n_o));

/* phc_pci_agent_model.sv */
// arbiter plus one pci target answering configuration cycles
module phc_pci_agent_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [31:0] rd_data_i,
    input  wire logic        req_n_i,
    input  wire logic        frame_n_i,
    input  wire logic        irdy_n_i,
    input  wire logic        ad_oe_n_i,
    input  wire logic [31:0] ad_drv_i,
    output logic             gnt_n_o,
    output logic             devsel_n_o,
    output logic             trdy_n_o,
    output logic             stop_n_o,
    output logic      [31:0] ad_o,
    output logic      [31:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // mode 0 answers, 1 silent, 2 target abort, 3 retry
    // ****************************************
    logic [31:0] last_reg;
    // undriven bus toggles so a stale value never looks valid
    assign ad_o = !ad_oe_n_i ? ad_drv_i : (!trdy_n_o ? rd_data_i : ~last_reg);
    always_ff @(posedge clk_i) begin
        last_reg <= ad_o;
        gnt_n_o <= rst_i | req_n_i;
        if (!frame_n_i && irdy_n_i) begin
            addr_o <= ad_drv_i;
        end
        // hold the termination until irdy is released
        devsel_n_o <= rst_i | irdy_n_i | ^mode_i;
        trdy_n_o <= rst_i | irdy_n_i | (mode_i != 2'h0);
        stop_n_o <= rst_i | irdy_n_i | !mode_i[1];
    end
endmodule // phc_pci_agent_model

/* phc_cfg_engine_tb.sv */
// self-checking bench for the configuration engine
`include "phc_regs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module phc_cfg_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [1:0]  mode = 2'h0;
    logic [31:0] r, seen, ad_in, ad_out, wb_rd;
    logic [1:0]  c;
    logic        wb_ack, wb_err, wb_rty, ad_oe_n, frame_n, irdy_n, req_n;
    logic        gnt_n, devsel_n, trdy_n, stop_n;
    int          errors = 0;
    int          checks_done = 0;
    always #2 clk_i = ~clk_i;
    phc_cfg_engine phc_cfg_engine_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .wb_err_o(wb_err),
        .wb_rty_o(wb_rty), .pci_ad_i(ad_in), .pci_ad_o(ad_out), .pci_ad_oe_n_o(ad_oe_n),
        .pci_cbe_n_o(), .pci_cbe_oe_n_o(), .pci_par_o(), .pci_par_oe_n_o(),
        .pci_frame_n_o(frame_n), .pci_frame_oe_n_o(), .pci_irdy_n_o(irdy_n),
        .pci_irdy_oe_n_o(), .pci_req_n_o(req_n), .pci_gnt_n_i(gnt_n),
        .pci_devsel_n_i(devsel_n), .pci_trdy_n_i(trdy_n), .pci_stop_n_i(stop_n),
        .pci_perr_n_i(1'b1), .pci_serr_n_i(1'b1), .ext_idsel_i(1'b0), .self_idsel_o());
    phc_pci_agent_model phc_pci_agent_model_i (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode),
        .rd_data_i(32'ha55a_5aa5), .req_n_i(req_n), .frame_n_i(frame_n), .irdy_n_i(irdy_n),
        .ad_oe_n_i(ad_oe_n), .ad_drv_i(ad_out), .gnt_n_o(gnt_n), .devsel_n_o(devsel_n),
        .trdy_n_o(trdy_n), .stop_n_o(stop_n), .ad_o(ad_in), .addr_o(seen));
    // ****************************************
    // bus cycles and scenarios
    // ****************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input int lim);
        int n;
        n = 0;
        c = 2'h3;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hf;
        while (c == 2'h3 && n < lim) begin
            @(posedge clk_i);
            n++;
            c = wb_ack === 1'b1 ? 2'h0 : wb_err === 1'b1 ? 2'h1 : wb_rty === 1'b1 ? 2'h2 : 2'h3;
        end
        r = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // data-port access through a freshly loaded address port
    task automatic cfg(input logic [31:0] a, input logic [1:0] m, input logic w);
        wb(1'b1, `PHC_ADDR_OFS, a, 20);
        mode <= m;
        wb(w, `PHC_DATA_OFS, 32'h1234_5678, 200);
    endtask
    task t_regs;
        wb(1'b0, `PHC_BUSN_OFS, 32'h0, 20);
        `CHK(r, 32'h0)
        wb(1'b1, `PHC_BUSN_OFS, 32'h0200_0000, 20);
        wb(1'b0, `PHC_BUSN_OFS, 32'h0, 20);
        `CHK(r, 32'h0200_0000)
        wb(1'b0, 8'h14, 32'h0, 20);
        `CHK(c, 2'h1)
        wb(1'b1, `PHC_CTRL_OFS, 32'h3, 20);
    endtask
    task t_range;
        cfg(32'h0008_0300, 2'h0, 1'b0);
        `CHK(c, 2'h3)
    endtask
    task t_types;
        cfg(32'h0008_0000, 2'h0, 1'b0);
        `CHK(r, 32'ha55a_5aa5)
        `CHK(seen[17:16], 2'h2)
        `CHK(seen[1:0], 2'h0)
        cfg(32'h0008_0200, 2'h0, 1'b0);
        `CHK(c, 2'h0)
        `CHK(seen[1:0], 2'h1)
        `CHK(seen[23:16], 8'h02)
    endtask
    task t_aborts;
        cfg(32'h0010_0000, 2'h1, 1'b0);
        `CHK(r, 32'hffff_ffff)
        cfg(32'h0008_0000, 2'h2, 1'b1);
        wb(1'b0, `PHC_STAT_OFS, 32'h0, 20);
        `CHK(r[7:0], 8'h20)
        wb(1'b1, `PHC_DATA_OFS, 32'h0, 20);
        `CHK(c, 2'h1)
        wb(1'b1, `PHC_STAT_OFS, 32'h20, 20);
        wb(1'b0, `PHC_STAT_OFS, 32'h0, 20);
        `CHK(r[7:0], 8'h00)
        cfg(32'h0008_0000, 2'h3, 1'b0);
        `CHK(c, 2'h2)
        cfg(32'h0008_0000, 2'h3, 1'b1);
        `CHK(c, 2'h2)
        wb(1'b0, `PHC_STAT_OFS, 32'h0, 20);
        `CHK(r[7:0], 8'h80)
        wb(1'b1, `PHC_STAT_OFS, 32'h80, 20);
        cfg(32'h0008_0000, 2'h0, 1'b1);
        `CHK(c, 2'h0)
    endtask
    task complete_run;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_range;
        t_types;
        t_aborts;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        complete_run;
    end
endmodule // phc_cfg_engine_tb
